// ===== shared/wemb_pkg.sv
// constants and types of the wide external memory bus
// Overview of operation
// R01 - bus width bit selects 16-bit bus
// R02 - sixteen shared pins, four upper address pins
// R03 - byte address output always driven
// R04 - one read enable fetches whole word
// R05 - four quarters, latch strobe in first
// R06 - external latch captures on strobe fall
// R07 - read enable low third through fourth quarter
// R08 - read word sampled at read enable rise
// R09 - table transfers bytewise, any byte address
// R10 - write mode ignored in 8-bit mode
// R11 - control register power-on defaults
// R12 - bus disable releases pins to ports
// R13 - program RAM bit maps internal program RAM
// R14 - cleared program RAM bit keeps data RAM
// R15 - wait field adds zero to three cycles
// R16 - word write pairs bytes, strobe on second
// R17 - byte select copies byte, enables half
// R18 - byte write strobes low or high line
// R19 - three bytes form 21-bit pointer
// R20 - pointer bit 0 on byte address, rest on pins
// R21 - table read loads latch, may increment
// R22 - address bit 0 picks bus byte
// R23 - table write two cycles plus waits
// R24 - even address low strobe, odd high
package wemb_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses of aligned words)
   // ---------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_LATCH = 12'h004;
   localparam logic [11:0] OFS_PTR_LOW = 12'h008;
   localparam logic [11:0] OFS_PTR_HIGH = 12'h00C;
   localparam logic [11:0] OFS_PTR_UPPER = 12'h010;
   localparam logic [11:0] OFS_CMD = 12'h014;
   localparam logic [11:0] OFS_STATUS = 12'h018;
   localparam logic [11:0] OFS_CONFIG = 12'h01C;
   localparam logic [11:0] OFS_FETCH_ADDR = 12'h020;
   localparam logic [11:0] OFS_FETCH_DATA = 12'h024;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTL_BUS_DISABLE = 7;
   localparam int CTL_PROGRAM_RAM = 6;
   localparam int CTL_WAIT_HI = 5;
   localparam int CTL_WAIT_LO = 4;
   localparam int CTL_WM_HI = 1;
   localparam int CTL_WM_LO = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CTL_MASK = 8'hF3;
   localparam int CFG_BUS_WIDTH = 6;
   localparam logic [7:0] CFG_RESET = 8'h40;
   // command register bits
   localparam int CMD_TBL_READ = 0;
   localparam int CMD_TBL_WRITE = 1;
   localparam int CMD_POST_INC = 2;
   localparam int CMD_FETCH = 3;
   // ---------------------------------------------------------------
   // memory map and timing
   // ---------------------------------------------------------------
   localparam logic [20:0] PRAM_BASE = 21'h1F_FE00;
   localparam logic [15:0] DRAM_BASE = 16'h0400;
   localparam logic [15:0] DRAM_LAST = 16'h05FF;
   localparam int PRAM_BYTES = 512;
   localparam int QUARTERS = 4;
   localparam int MAX_WAIT = 3;
   typedef enum logic [1:0] {WM_BYTE_WRITE, WM_BYTE_SELECT, WM_WORD_WRITE} wemb_wm_t;
endpackage

// ===== rtl/wemb_quarter.sv
// quarter sequencer: two-bit quarter count and last-quarter pulse of an instruction cycle
`timescale 1ns/1ps
module wemb_quarter import wemb_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // quarter outputs
   output logic [1:0] quarter,
   output logic cycle_end
);
   typedef struct packed {logic [1:0] q;} wemb_q_state_t;
   wemb_q_state_t s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.q = s_r.q + 2'd1; // R05
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign quarter = s_r.q;
   assign cycle_end = (s_r.q == 2'(QUARTERS - 1));
endmodule // wemb_quarter

// ===== rtl/wemb_prog_ram.sv
// internal 512-byte ram, usable as program or data memory
`timescale 1ns/1ps
module wemb_prog_ram import wemb_pkg::*; #(
   parameter int DEPTH = PRAM_BYTES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte port
   input wire logic [8:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   typedef struct packed {logic [DEPTH-1:0][7:0] mem;} wemb_ram_state_t;
   wemb_ram_state_t s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (wr_en) begin
         s_nxt.mem[addr] = wr_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign rd_data = s_r.mem[addr];
endmodule // wemb_prog_ram

// ===== rtl/wemb_bus.sv
// multiplexed 16-bit external program memory bus with table transfers
`timescale 1ns/1ps
module wemb_bus import wemb_pkg::*; (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // shared address/data pins
   input wire logic [15:0] SHARED_ADDR_DATA_PINS_IN,
   output logic [15:0] SHARED_ADDR_DATA_PINS_OUT,
   output logic [15:0] SHARED_ADDR_DATA_PINS_OE_N,
   // address and control pins
   output logic [3:0] UPPER_ADDRESS_PINS,
   output logic ADDR_LATCH_STROBE,
   output logic READ_ENABLE_N,
   output logic LOW_WRITE_STROBE_N,
   output logic HIGH_WRITE_STROBE_N,
   output logic UPPER_BYTE_ENABLE_N,
   output logic LOWER_BYTE_ENABLE_N,
   output logic BYTE_ADDRESS_OUT,
   // port takeover when bus disabled
   output logic PORT_MODE
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum {ST_IDLE, ST_FETCH, ST_TRD, ST_TWR, ST_WAIT} wemb_st_t;
   typedef struct packed {
      wemb_st_t st;
      logic [7:0] ctl;
      logic [7:0] cfg;
      logic [7:0] latch;
      logic [20:0] ptr;
      logic [7:0] hold;
      logic [20:0] faddr;
      logic [15:0] fdata;
      logic [2:0] cycles;
      logic [1:0] waits;
      logic inc;
      logic busy;
      logic [31:0] prdata;
      logic ale;
      logic oe_n;
      logic wrl_n;
      logic wrh_n;
      logic ub_n;
      logic lb_n;
      logic ba0;
      logic [15:0] ad_out;
      logic [15:0] ad_oe_n;
      logic [3:0] upper;
   } wemb_state_t;
   wemb_state_t s_r, s_nxt;

   logic [1:0] quarter;
   logic cycle_end;
   logic [8:0] ram_addr;
   logic ram_wr;
   logic [7:0] ram_rd;
   logic wide;
   logic [1:0] wm;
   logic apb_wr;
   logic apb_rd;
   logic in_pram;

   // wait field 11 -> 0 .. 00 -> 3
   function automatic logic [1:0] wait_count(input logic [1:0] f);
      return 2'(MAX_WAIT) - f; // R15
   endfunction
   function automatic logic is_pram(input logic [20:0] a);
      return a >= PRAM_BASE;
   endfunction

   wemb_quarter u_quarter (
      .clk(CLOCK),
      .rst_n(RST_N),
      .quarter(quarter),
      .cycle_end(cycle_end)
   );

   assign wide = s_r.cfg[CFG_BUS_WIDTH]; // R01
   assign wm = wide ? s_r.ctl[CTL_WM_HI:CTL_WM_LO] : 2'd0; // R10
   assign apb_wr = PSEL && PENABLE && PWRITE;
   assign apb_rd = PSEL && !PENABLE && !PWRITE;
   assign in_pram = s_r.ctl[CTL_PROGRAM_RAM] && is_pram(s_r.st == ST_FETCH ? s_r.faddr : s_r.ptr);
   // ram address follows the APB address whenever the access does not fall in program ram
   assign ram_addr = in_pram ? (s_r.st == ST_FETCH ? s_r.faddr[8:0] : s_r.ptr[8:0])
                             : 9'(PADDR[10:2]);
   assign ram_wr = in_pram && s_r.st == ST_TWR && cycle_end && s_r.cycles == 3'd0;

   wemb_prog_ram u_ram (
      .clk(CLOCK),
      .rst_n(RST_N),
      .addr(ram_addr),
      .wr_en(ram_wr),
      .wr_data(s_r.latch),
      .rd_data(ram_rd)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic ext;
      logic [15:0] word;
      ext = 1'b0;
      word = '0;
      s_nxt = s_r;
      // register reads
      if (apb_rd) begin
         case (PADDR)
            OFS_CTRL: s_nxt.prdata = {24'h0, s_r.ctl};
            OFS_LATCH: s_nxt.prdata = {24'h0, s_r.latch};
            OFS_PTR_LOW: s_nxt.prdata = {24'h0, s_r.ptr[7:0]};
            OFS_PTR_HIGH: s_nxt.prdata = {24'h0, s_r.ptr[15:8]};
            OFS_PTR_UPPER: s_nxt.prdata = {27'h0, s_r.ptr[20:16]}; // R19
            OFS_STATUS: s_nxt.prdata = {31'h0, s_r.busy};
            OFS_CONFIG: s_nxt.prdata = {24'h0, s_r.cfg};
            OFS_FETCH_ADDR: s_nxt.prdata = {11'h0, s_r.faddr};
            OFS_FETCH_DATA: s_nxt.prdata = {16'h0, s_r.fdata};
            default: s_nxt.prdata = '0;
         endcase
      end
      // register writes; pointer and latch locked while busy
      if (apb_wr && !s_r.busy) begin
         case (PADDR)
            OFS_CTRL: s_nxt.ctl = PWDATA[7:0] & CTL_MASK;
            OFS_LATCH: s_nxt.latch = PWDATA[7:0];
            OFS_PTR_LOW: s_nxt.ptr[7:0] = PWDATA[7:0];
            OFS_PTR_HIGH: s_nxt.ptr[15:8] = PWDATA[7:0];
            OFS_PTR_UPPER: s_nxt.ptr[20:16] = PWDATA[4:0]; // R19
            OFS_CONFIG: s_nxt.cfg = PWDATA[7:0] & CFG_RESET;
            OFS_FETCH_ADDR: s_nxt.faddr = PWDATA[20:0];
            OFS_CMD: begin
               s_nxt.inc = PWDATA[CMD_POST_INC];
               s_nxt.busy = PWDATA[3:0] != 4'h0;
               s_nxt.waits = wait_count(s_r.ctl[CTL_WAIT_HI:CTL_WAIT_LO]);
               s_nxt.cycles = 3'd1; // R23
               if (PWDATA[CMD_FETCH]) s_nxt.st = ST_FETCH;
               else if (PWDATA[CMD_TBL_READ]) s_nxt.st = ST_TRD;
               else if (PWDATA[CMD_TBL_WRITE]) s_nxt.st = ST_TWR;
               else s_nxt.st = ST_IDLE;
            end
            default: ;
         endcase
      end
      // idle bus levels
      s_nxt.ale = 1'b0;
      s_nxt.oe_n = 1'b1;
      s_nxt.wrl_n = 1'b1;
      s_nxt.wrh_n = 1'b1;
      s_nxt.ub_n = 1'b1;
      s_nxt.lb_n = 1'b1;
      s_nxt.ad_oe_n = 16'hFFFF;
      ext = !s_r.ctl[CTL_BUS_DISABLE] && !in_pram; // R12 R13 R14
      case (s_r.st)
         ST_FETCH, ST_TRD, ST_TWR: begin
            word = (s_r.st == ST_FETCH) ? s_r.faddr[20:5] : s_r.ptr[16:1];
            // bus cycle shape: address in Q1, data phase Q3-Q4
            // address launched at the end of the first cycle so the strobe stands in Q1;
            // pins stay quiet in a partial first cycle after the command lands
            if (ext && cycle_end && s_r.cycles == 3'd1) begin
               s_nxt.ale = 1'b1; // R05
               s_nxt.ad_out = (s_r.st == ST_FETCH) ? s_r.faddr[15:0] : word; // R02
               s_nxt.ad_oe_n = 16'h0000;
               s_nxt.upper = (s_r.st == ST_FETCH) ? s_r.faddr[19:16] : s_r.ptr[20:17]; // R20
               s_nxt.ba0 = (s_r.st == ST_FETCH) ? 1'b0 : s_r.ptr[0]; // R03 R20
            end
            if (ext && s_r.cycles == 3'd0 && s_r.st != ST_TWR
                && (quarter == 2'd1 || quarter == 2'd2)) begin
               s_nxt.oe_n = 1'b0; // R04 R07
               s_nxt.ub_n = 1'b0;
               s_nxt.lb_n = 1'b0;
            end
            if (ext && s_r.cycles == 3'd0 && s_r.st == ST_TWR
                && (quarter == 2'd1 || quarter == 2'd2)) begin
               s_nxt.ad_out = {s_r.latch, s_r.latch}; // R17 R18
               s_nxt.ad_oe_n = 16'h0000;
               case (wm)
                  2'd0: begin
                     s_nxt.wrl_n = s_r.ptr[0]; // R18 R24
                     s_nxt.wrh_n = !s_r.ptr[0]; // R24
                  end
                  2'd1: begin
                     s_nxt.wrh_n = 1'b0; // R17
                     s_nxt.ub_n = !s_r.ptr[0];
                     s_nxt.lb_n = s_r.ptr[0];
                  end
                  default: begin
                     if (s_r.ptr[0]) begin
                        s_nxt.ad_out = {s_r.latch, s_r.hold}; // R16
                        s_nxt.wrh_n = 1'b0;
                        s_nxt.ub_n = 1'b0;
                        s_nxt.lb_n = 1'b0;
                     end else begin
                        s_nxt.ad_oe_n = 16'hFFFF;
                     end
                  end
               endcase
               if (!wide) begin
                  s_nxt.ad_out = {8'h00, s_r.latch};
                  s_nxt.wrh_n = 1'b1;
                  s_nxt.wrl_n = 1'b0;
               end
            end
            if (cycle_end) begin
               if (s_r.cycles != 3'd0) begin
                  s_nxt.cycles = s_r.cycles - 3'd1;
               end else if (s_r.st == ST_FETCH) begin
                  // read enable rises at this edge, word captured with it
                  s_nxt.fdata = in_pram ? {8'h00, ram_rd} : SHARED_ADDR_DATA_PINS_IN; // R08
                  s_nxt.st = ST_IDLE;
                  s_nxt.busy = 1'b0;
               end else begin
                  if (s_r.st == ST_TRD) begin
                     if (in_pram) s_nxt.latch = ram_rd;
                     else if (!wide || !s_r.ptr[0])
                        s_nxt.latch = SHARED_ADDR_DATA_PINS_IN[7:0]; // R09 R21 R22
                     else s_nxt.latch = SHARED_ADDR_DATA_PINS_IN[15:8]; // R22
                  end else if (!s_r.ptr[0]) begin
                     s_nxt.hold = s_r.latch; // R16
                  end
                  if (s_r.inc) s_nxt.ptr = s_r.ptr + 21'd1; // R21
                  s_nxt.st = (s_r.waits != 2'd0) ? ST_WAIT : ST_IDLE;
                  s_nxt.busy = s_r.waits != 2'd0;
               end
            end
         end
         ST_WAIT: begin
            if (cycle_end) begin
               s_nxt.waits = s_r.waits - 2'd1; // R15
               if (s_r.waits == 2'd1) begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.busy = 1'b0;
               end
            end
         end
         default: ;
      endcase
      // disabled bus: drivers left to the port logic
      if (s_r.ctl[CTL_BUS_DISABLE]) begin
         s_nxt.ad_oe_n = 16'hFFFF; // R12
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.ctl <= CTL_RESET; // R11
         s_r.cfg <= CFG_RESET;
         s_r.oe_n <= 1'b1;
         s_r.wrl_n <= 1'b1;
         s_r.wrh_n <= 1'b1;
         s_r.ub_n <= 1'b1;
         s_r.lb_n <= 1'b1;
         s_r.ad_oe_n <= 16'hFFFF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // data ram window reads 00h when program ram is off
   assign PRDATA = (!s_r.ctl[CTL_PROGRAM_RAM] && PADDR >= 12'h800 && s_r.prdata == '0)
                   ? 32'h0000_0000 : s_r.prdata;
   assign PREADY = PSEL && PENABLE;
   assign PSLVERR = 1'b0;
   assign SHARED_ADDR_DATA_PINS_OUT = s_r.ad_out;
   assign SHARED_ADDR_DATA_PINS_OE_N = s_r.ad_oe_n;
   assign UPPER_ADDRESS_PINS = s_r.upper;
   assign ADDR_LATCH_STROBE = s_r.ale;
   assign READ_ENABLE_N = s_r.oe_n;
   assign LOW_WRITE_STROBE_N = s_r.wrl_n;
   assign HIGH_WRITE_STROBE_N = s_r.wrh_n;
   assign UPPER_BYTE_ENABLE_N = s_r.ub_n;
   assign LOWER_BYTE_ENABLE_N = s_r.lb_n;
   assign BYTE_ADDRESS_OUT = s_r.ba0; // R03
   assign PORT_MODE = s_r.ctl[CTL_BUS_DISABLE]; // R12
endmodule // wemb_bus

// ===== rtl/unused_placeholder_none.sv
// intentionally empty module-free file
`timescale 1ns/1ps

// ===== verif/wemb_bus_assertions.sv
// checker of pin timing on the wide memory bus
`timescale 1ns/1ps
module wemb_bus_assertions (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // bus pins
   input wire logic [15:0] SHARED_ADDR_DATA_PINS_OE_N,
   input wire logic ADDR_LATCH_STROBE,
   input wire logic READ_ENABLE_N,
   input wire logic LOW_WRITE_STROBE_N,
   input wire logic HIGH_WRITE_STROBE_N,
   input wire logic PORT_MODE
);
   // ---------------------------------------------------------------
   // pin relations
   // ---------------------------------------------------------------
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   a_strobe_one_clock: assert property ($rose(ADDR_LATCH_STROBE) |=> !ADDR_LATCH_STROBE)
      else $error("latch strobe too long");
   a_addr_on_strobe: assert property (ADDR_LATCH_STROBE |-> SHARED_ADDR_DATA_PINS_OE_N == 0)
      else $error("address not driven under strobe");
   a_read_two_clocks: assert property ($fell(READ_ENABLE_N) |=> !READ_ENABLE_N ##1 READ_ENABLE_N)
      else $error("read enable width wrong");
   a_read_after_strobe: assert property ($fell(READ_ENABLE_N) |-> $past(ADDR_LATCH_STROBE, 2))
      else $error("read enable not in third quarter");
   a_read_bus_free: assert property (!READ_ENABLE_N |-> &SHARED_ADDR_DATA_PINS_OE_N)
      else $error("device drives bus while reading");
   a_one_write_line: assert property (!(!LOW_WRITE_STROBE_N && !HIGH_WRITE_STROBE_N))
      else $error("both write lines low");
   a_low_write_width: assert property ($fell(LOW_WRITE_STROBE_N) |=> !LOW_WRITE_STROBE_N ##1 LOW_WRITE_STROBE_N)
      else $error("low write strobe width wrong");
   a_port_mode_quiet: assert property (PORT_MODE |-> &SHARED_ADDR_DATA_PINS_OE_N && READ_ENABLE_N)
      else $error("bus active in port mode");
   c_read: cover property ($fell(READ_ENABLE_N));
   c_low_write: cover property ($fell(LOW_WRITE_STROBE_N));
   c_high_write: cover property ($fell(HIGH_WRITE_STROBE_N));
endmodule // wemb_bus_assertions
bind wemb_bus wemb_bus_assertions u_wemb_bus_assertions (
   .CLOCK(CLOCK),
   .RST_N(RST_N),
   .SHARED_ADDR_DATA_PINS_OE_N(SHARED_ADDR_DATA_PINS_OE_N),
   .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE),
   .READ_ENABLE_N(READ_ENABLE_N),
   .LOW_WRITE_STROBE_N(LOW_WRITE_STROBE_N),
   .HIGH_WRITE_STROBE_N(HIGH_WRITE_STROBE_N),
   .PORT_MODE(PORT_MODE)
);

// ===== verif/wemb_mem_model.sv
// word-wide external memory behind an address latch
`timescale 1ns/1ps
module wemb_mem_model (
   // device pins
   input wire logic clk,
   input wire logic [15:0] ad_out,
   input wire logic [3:0] upper,
   input wire logic ale,
   input wire logic ba,
   input wire logic re_n,
   input wire logic wrl_n,
   input wire logic wrh_n,
   input wire logic ub_n,
   input wire logic lb_n,
   // read data
   output logic [15:0] ad_in
);
   logic [15:0] mem [256];
   logic [7:0] lat_r;
   logic [3:0] up_r;
   logic ba_r;
   logic [15:0] last_r;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = {~8'(i), 8'(i)};
      end
   end
   // value held while the strobe is high is the one kept at its fall
   always @(posedge clk) begin
      if (ale) begin
         lat_r <= ad_out[7:0];
         up_r <= upper;
         ba_r <= ba;
      end
      if (!wrh_n && !(ub_n && !lb_n)) mem[lat_r][15:8] <= ad_out[15:8];
      if (!wrl_n || (!wrh_n && !lb_n)) mem[lat_r][7:0] <= ad_out[7:0];
      last_r <= ad_in;
   end
   // released bus toggles so a late sample never reads stale data
   assign ad_in = !re_n ? mem[lat_r] : ~last_r;
endmodule // wemb_mem_model

// ===== verif/wemb_bus_bench.sv
// self-checking bench of the wide memory bus
`timescale 1ns/1ps
module wemb_bus_bench import wemb_pkg::*;;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic ale, re_n, wrl_n, wrh_n, ub_n, lb_n, ba, pmode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] ad_in, ad_out, ad_oe_n;
   logic [3:0] upper;
   int failures, samples_checked, cyc;
   int t_rise;
   logic re_q;
   int d [4];
   wemb_bus u_wemb_bus (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SHARED_ADDR_DATA_PINS_IN(ad_in),
      .SHARED_ADDR_DATA_PINS_OUT(ad_out), .SHARED_ADDR_DATA_PINS_OE_N(ad_oe_n),
      .UPPER_ADDRESS_PINS(upper), .ADDR_LATCH_STROBE(ale), .READ_ENABLE_N(re_n),
      .LOW_WRITE_STROBE_N(wrl_n), .HIGH_WRITE_STROBE_N(wrh_n), .UPPER_BYTE_ENABLE_N(ub_n),
      .LOWER_BYTE_ENABLE_N(lb_n), .BYTE_ADDRESS_OUT(ba), .PORT_MODE(pmode));
   wemb_mem_model u_wemb_mem_model (.clk(clk), .ad_out(ad_out), .upper(upper), .ale(ale),
      .ba(ba), .re_n(re_n), .wrl_n(wrl_n), .wrh_n(wrh_n), .ub_n(ub_n), .lb_n(lb_n),
      .ad_in(ad_in));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // edge at which the last read enable rose, the end of a bus cycle
   always @(posedge clk) begin
      re_q <= re_n;
      if (re_n && !re_q) t_rise <= cyc;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      int n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 0;
      penable <= 0;
      if (n >= 50) begin
         failures++;
         report_and_stop();
      end
   endtask
   task automatic idle;
      int n;
      n = 0;
      do begin
         apb(0, OFS_STATUS, 0);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      if (n >= 100) begin
         failures++;
         report_and_stop();
      end
   endtask
   task automatic op(input logic [20:0] p, input logic [7:0] cmd);
      apb(1, OFS_PTR_LOW, 32'(p[7:0]));
      apb(1, OFS_PTR_HIGH, 32'(p[15:8]));
      apb(1, OFS_PTR_UPPER, 32'(p[20:16]));
      apb(1, OFS_CMD, 32'(cmd));
      idle();
   endtask
   // even byte, then odd byte of one word, in a given write mode
   task automatic wr_pair(input logic [1:0] wm, input logic [7:0] w, lo, hi);
      logic [15:0] mid;
      mid = (wm == 2'b10) ? {~w, w} : {~w, lo};
      apb(1, OFS_CTRL, {28'h000_0003, 2'b00, wm});
      apb(1, OFS_LATCH, 32'(lo));
      op({12'h000, w, 1'b0}, 8'h02);
      check("even write", 32'(u_wemb_mem_model.mem[w]), 32'(mid));
      apb(1, OFS_LATCH, 32'(hi));
      op({12'h000, w, 1'b1}, 8'h02);
      check("pair write", 32'(u_wemb_mem_model.mem[w]), 32'({hi, lo}));
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      apb(0, OFS_CTRL, 0);
      check("control reset", q, 32'h0000_0000);
      apb(0, OFS_CONFIG, 0);
      check("bus width", q, 32'h0000_0040);
      apb(1, OFS_CTRL, 32'h0000_00FF);
      apb(0, OFS_CTRL, 0);
      check("control mask", q, 32'h0000_00F3);
      check("port mode", 32'(pmode), 1);
      check("bus released", 32'(ad_oe_n), 32'h0000_FFFF);
      apb(1, OFS_CTRL, 32'h0000_0030);
      @(posedge clk);
      check("port mode off", 32'(pmode), 0);
      apb(0, 12'h3FC, 0);
      check("unmapped", q, 32'h0000_0000);
      check("slave error", 32'(pslverr), 0);
   endtask
   task automatic t_read;
      apb(1, OFS_FETCH_ADDR, 32'h0000_0012);
      apb(1, OFS_CMD, 32'h0000_0008);
      idle();
      apb(0, OFS_FETCH_DATA, 0);
      check("fetch word", 32'(q[15:0]), 32'h0000_ED12);
      op(21'h0A_0024, 8'h05);
      apb(0, OFS_LATCH, 0);
      check("even byte", q, 32'h0000_0012);
      apb(1, OFS_CMD, 32'h0000_0005);
      idle();
      apb(0, OFS_LATCH, 0);
      check("odd byte", q, 32'h0000_00ED);
      check("byte address", 32'(u_wemb_mem_model.ba_r), 1);
      check("upper pins", 32'(u_wemb_mem_model.up_r), 32'h0000_0005);
      apb(0, OFS_PTR_LOW, 0);
      check("post increment", q, 32'h0000_0026);
   endtask
   // busy ends 4 clocks per wait after the bus cycle, seen within one poll of 3 clocks
   task automatic t_wait;
      for (int w = 0; w < 4; w++) begin
         apb(1, OFS_CTRL, 32'(w << 4));
         op(21'h00_0010, 8'h01);
         d[w] = cyc - t_rise;
         check("wait cycles", 32'(d[w] >= 13 - 4 * w && d[w] <= 15 - 4 * w), 1);
      end
   endtask
   // narrow bus: write mode field ignored, byte goes out on the low strobe
   task automatic t_narrow;
      apb(1, OFS_CONFIG, 0);
      apb(0, OFS_CONFIG, 0);
      check("narrow width", q, 32'h0000_0000);
      apb(1, OFS_CTRL, 32'h0000_0031);
      apb(1, OFS_LATCH, 32'h0000_005E);
      op(21'h00_0047, 8'h02);
      check("narrow write", 32'(u_wemb_mem_model.mem[8'h23]), 32'h0000_DC5E);
   endtask
   task automatic t_pram;
      apb(1, OFS_CTRL, 32'h0000_0070);
      apb(1, OFS_LATCH, 32'h0000_0077);
      op(21'h1F_FE10, 8'h02);
      apb(1, OFS_LATCH, 0);
      op(21'h1F_FE10, 8'h01);
      apb(0, OFS_LATCH, 0);
      check("program ram", q, 32'h0000_0077);
      check("external kept", 32'(u_wemb_mem_model.mem[8'h08]), 32'h0000_F708);
      apb(1, OFS_CTRL, 32'h0000_0030);
      op(21'h1F_FE10, 8'h01);
      apb(0, OFS_LATCH, 0);
      check("external read", q, 32'h0000_0008);
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, cyc} = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_read();
      wr_pair(2'b00, 8'h20, 8'h3C, 8'hC3);
      wr_pair(2'b01, 8'h21, 8'hA5, 8'h5A);
      wr_pair(2'b10, 8'h22, 8'h11, 8'h22);
      t_wait();
      t_pram();
      t_narrow();
      report_and_stop();
   end
endmodule // wemb_bus_bench
